// [rtl/drpc_map.vh]
// Constants for the descriptor ring and primitive control block
`ifndef DRPC_MAP_VH
`define DRPC_MAP_VH
// Primitive register command and answer words
`define DRPC_PRIM_INIT        16'h4200
`define DRPC_PRIM_START       16'h4300
`define DRPC_PRIM_STOP        16'h4400
`define DRPC_PRIM_SELFTEST    16'h4100
`define DRPC_PRIM_INIT_CONF   16'h0242
`define DRPC_PRIM_CLR_AVAIL   16'h0040
`define DRPC_PRIM_AVAIL_BIT   6
`define DRPC_PRIM_PASS_BIT    4
`define DRPC_BUSCFG_TEST_BIT  4
// Descriptor word field positions
`define DRPC_DESC_OWN_BIT     15
`define DRPC_DESC_SOC_BIT     13
`define DRPC_DESC_EOC_BIT     12
// Status buffer codes
`define DRPC_LSTATE_XFER      8'h00
`define DRPC_LSTATE_DISC      8'h04
`define DRPC_PHASE_STOPPED    8'hFF
`define DRPC_PHASE_XFER       8'h03
// Self test result codes
`define DRPC_ST_PASS          3'h0
`define DRPC_ST_RESET_FAIL    3'h1
`define DRPC_ST_RAM_FAIL      3'h2
`define DRPC_ST_ALU_FAIL      3'h3
`define DRPC_ST_TIMER_FAIL    3'h4
`define DRPC_ST_TXRX_FAIL     3'h5
`define DRPC_ST_REG_FAIL      3'h6
// Timing: self test limit in microseconds, at 40 MHz
`define DRPC_ST_LIMIT_US      75000
`define DRPC_CLK_MHZ          40
`define DRPC_ST_LIMIT_CYC     (`DRPC_ST_LIMIT_US * `DRPC_CLK_MHZ)
`define DRPC_ST_RUN_CYC       64
// Ring geometry
`define DRPC_RING_BITS        3
`define DRPC_FIFO_DEPTH       16
`define DRPC_FIFO_AW          4
`endif

// [rtl/drpc_fifo.v]
// Octet FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module drpc_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             SYS_CLK,
    input  wire             NRST,
    input  wire             FLUSH,
    input  wire [WIDTH-1:0] IN_DATA,
    input  wire             IN_VALID,
    output wire             IN_READY,
    output wire [WIDTH-1:0] OUT_DATA,
    output wire             OUT_VALID,
    input  wire             OUT_READY
);
    reg  [WIDTH-1:0] mem [0:DEPTH-1];
    reg  [AW:0]      wr_q;
    reg  [AW:0]      rd_q;
    wire             full;
    wire             empty;
    wire             push;
    wire             pop;

    assign full      = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    assign empty     = (wr_q == rd_q);
    assign IN_READY  = !full;
    assign OUT_VALID = !empty;
    assign OUT_DATA  = mem[rd_q[AW-1:0]];
    assign push      = IN_VALID && !full;
    assign pop       = OUT_READY && !empty;

    always @(posedge SYS_CLK) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= IN_DATA;
        end
    end

    always @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            wr_q <= {(AW+1){1'b0}};
            rd_q <= {(AW+1){1'b0}};
        end else if (FLUSH) begin
            wr_q <= {(AW+1){1'b0}};
            rd_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule // drpc_fifo
`default_nettype wire

// [rtl/drpc_top.v]
// Descriptor ring and primitive control of a serial link controller
//
// Overview of operation
// R1: Transmit buffer length field is host bookkeeping; the device ignores it.
// R2: Message length is the octet count, held as 16-bit two's complement.
// R3: Local state reads 0 in data transfer, 4 when disconnected.
// R4: Phase reads -1 when stopped, 3 in data transfer.
// R5: Receive ring pointer names the next receive descriptor to fill.
// R6: Transmit ring pointer names the next transmit descriptor to send.
// R7: Writing 4200H starts the init block fetch from the init pointer.
// R8: Init completes with 0242H shown; host writes 0040H to clear availability.
// R9: Writing 4300H starts the link; idle flags then go out continuously.
// R10: Host waits for own flag clear before filling a transmit buffer.
// R11: Host chains descriptors with start, end and length, then sets own.
// R12: Host reads receive data when own is clear, then sets own.
// R13: Host appends receive buffers until one with end of chain set.
// R14: Stop ceases traffic, holds the line high, sets stop flag.
// R15: Stop aborts an outgoing frame and drops partial receive data.
// R16: Restart repeats init, or only start if nothing changed.
// R17: Self test covers all units but the DMA path; the code checks no unit and reports SELF_TEST_RESULT.
// R18: Host resets, sets bus config bit 4, requests test, polls.
// R19: Pass or fail shows in primitive bit 4, detail in code field.
// R20: Result codes 0 pass, 1 to 6 unit failures, else device failure.
// R21: Availability must rise within 75 ms of a self test request.
// R22: Host reruns after a pass directly, after a failure from reset.
// R23: Own set means the device holds the descriptor; released after ack.
// R24: Start and end of chain mark first and last buffers of a frame.
// R25: Descriptors are served in ring order, never one with own clear.
`timescale 1ns/1ps
`default_nettype none
`include "drpc_map.vh"
module drpc_top (
    input  wire        SYS_CLK,
    input  wire        NRST,
    input  wire [15:0] PRIM_WR_DATA,
    input  wire        PRIM_WR,
    output wire [15:0] PRIM_RD_DATA,
    input  wire [15:0] BUS_CONFIG,
    input  wire [31:0] INIT_POINTER,
    output reg         INIT_FETCH,
    output reg  [31:0] INIT_FETCH_ADDR,
    input  wire        INIT_FETCH_DONE,
    input  wire [2:0]  SELF_TEST_RESULT,
    output reg         STOP_FLAG,
    input  wire        STOP_FLAG_CLR,
    output reg         INT_ENABLE,
    input  wire        INT_ENABLE_SET,
    output reg  [7:0]  LOCAL_STATE,
    output reg  [7:0]  PHASE,
    output reg  [2:0]  RX_RING_POINTER,
    output reg  [2:0]  TX_RING_POINTER,
    input  wire [15:0] TX_DESC_FLAGS,
    input  wire [15:0] TX_DESC_MSG_LEN,
    input  wire [15:0] TX_DESC_BUF_LEN,
    output reg         TX_DESC_RELEASE,
    input  wire        TX_ACK,
    input  wire [7:0]  TX_DATA,
    input  wire        TX_DATA_VALID,
    output wire        TX_DATA_READY,
    output reg         SERIAL_TX_LINE,
    input  wire [15:0] RX_DESC_FLAGS,
    input  wire        RX_OCTET_VALID,
    input  wire [7:0]  RX_OCTET,
    input  wire        RX_FRAME_END,
    output reg         RX_DESC_RELEASE,
    output reg         RX_DESC_EOC,
    output reg  [15:0] RX_DESC_MSG_LEN
);
    localparam S_IDLE  = 3'd0;
    localparam S_INIT  = 3'd1;
    localparam S_RUN   = 3'd2;
    localparam S_TEST  = 3'd3;
    localparam S_STOP  = 3'd4;
    localparam [7:0] FLAG_OCTET = 8'h7E;
    localparam [31:0] ST_LIMIT  = `DRPC_ST_LIMIT_CYC;
    localparam [31:0] ST_RUN    = `DRPC_ST_RUN_CYC;

    // Two's complement of a 16-bit count
    function [15:0] neg16;
        input [15:0] v;
        begin
            neg16 = (~v) + 16'h0001;
        end
    endfunction

    reg  [2:0]  state_q;
    reg  [15:0] prim_q;
    reg  [31:0] st_cnt_q;
    reg  [7:0]  sh_q;
    reg  [2:0]  bit_q;
    reg  [15:0] tx_left_q;
    reg         tx_busy_q;
    reg         tx_wait_ack_q;
    reg  [15:0] rx_cnt_q;
    reg         rx_have_q;
    wire        running;
    wire        tx_own;
    wire        rx_own;
    wire        f_out_valid;
    wire [7:0]  f_out_data;
    wire        f_pop;
    wire        stop_cmd;

    assign PRIM_RD_DATA = prim_q;
    assign running  = (state_q == S_RUN);
    assign tx_own   = TX_DESC_FLAGS[`DRPC_DESC_OWN_BIT];
    assign rx_own   = RX_DESC_FLAGS[`DRPC_DESC_OWN_BIT];
    assign stop_cmd = PRIM_WR && (PRIM_WR_DATA == `DRPC_PRIM_STOP);
    // Pop one octet per octet boundary (bit_q == 7) while a frame is sent
    assign f_pop    = running && tx_busy_q && (bit_q == 3'd7) && f_out_valid;

    drpc_fifo #(
        .WIDTH (8),
        .DEPTH (`DRPC_FIFO_DEPTH),
        .AW    (`DRPC_FIFO_AW)
    ) u_fifo (
        .SYS_CLK   (SYS_CLK),
        .NRST      (NRST),
        .FLUSH     (!running), // [R15]
        .IN_DATA   (TX_DATA),
        .IN_VALID  (TX_DATA_VALID && running),
        .IN_READY  (TX_DATA_READY),
        .OUT_DATA  (f_out_data),
        .OUT_VALID (f_out_valid),
        .OUT_READY (f_pop)
    );

    // Primitive sequencing, status buffer and self test
    always @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            state_q         <= S_IDLE;
            prim_q          <= 16'h0000;
            st_cnt_q        <= 32'h00000000;
            INIT_FETCH      <= 1'b0;
            INIT_FETCH_ADDR <= 32'h00000000;
            STOP_FLAG       <= 1'b0;
            INT_ENABLE      <= 1'b0;
            LOCAL_STATE     <= `DRPC_LSTATE_DISC;
            PHASE           <= `DRPC_PHASE_STOPPED;
        end else begin
            INIT_FETCH <= 1'b0;
            if (INT_ENABLE_SET && running) begin
                INT_ENABLE <= 1'b1; // [R9]
            end
            if (STOP_FLAG_CLR) begin
                STOP_FLAG <= 1'b0;
            end
            if (PRIM_WR && PRIM_WR_DATA == `DRPC_PRIM_CLR_AVAIL) begin
                prim_q[`DRPC_PRIM_AVAIL_BIT] <= 1'b0; // [R8]
            end
            case (state_q)
                S_IDLE, S_STOP: begin
                    if (PRIM_WR && PRIM_WR_DATA == `DRPC_PRIM_INIT) begin
                        INIT_FETCH      <= 1'b1; // [R7]
                        INIT_FETCH_ADDR <= INIT_POINTER;
                        state_q         <= S_INIT;
                    end else if (PRIM_WR &&
                                 PRIM_WR_DATA == `DRPC_PRIM_START) begin
                        state_q     <= S_RUN; // [R9] [R16]
                        LOCAL_STATE <= `DRPC_LSTATE_XFER; // [R3]
                        PHASE       <= `DRPC_PHASE_XFER; // [R4]
                    end else if (PRIM_WR &&
                                 PRIM_WR_DATA == `DRPC_PRIM_SELFTEST &&
                                 BUS_CONFIG[`DRPC_BUSCFG_TEST_BIT]) begin
                        state_q  <= S_TEST; // [R18]
                        st_cnt_q <= 32'h00000000;
                    end
                end
                S_INIT: begin
                    if (INIT_FETCH_DONE) begin
                        prim_q  <= `DRPC_PRIM_INIT_CONF; // [R8]
                        state_q <= S_IDLE;
                    end
                end
                S_TEST: begin
                    // No unit is checked here; SELF_TEST_RESULT is given after ST_RUN cycles
                    st_cnt_q <= st_cnt_q + 32'h00000001; // [R17]
                    if (st_cnt_q + 32'h00000001 >= ST_RUN ||
                        st_cnt_q + 32'h00000001 >= ST_LIMIT) begin // [R21]
                        prim_q <= 16'h0000;
                        prim_q[`DRPC_PRIM_AVAIL_BIT] <= 1'b1; // [R19]
                        prim_q[`DRPC_PRIM_PASS_BIT] <=
                            (SELF_TEST_RESULT == `DRPC_ST_PASS); // [R19]
                        prim_q[10:8] <= SELF_TEST_RESULT; // [R20]
                        state_q <= S_IDLE;
                    end
                end
                S_RUN: begin
                    if (stop_cmd) begin
                        state_q     <= S_STOP; // [R14]
                        STOP_FLAG   <= 1'b1; // [R14]
                        INT_ENABLE  <= 1'b0; // [R14]
                        LOCAL_STATE <= `DRPC_LSTATE_DISC; // [R3]
                        PHASE       <= `DRPC_PHASE_STOPPED; // [R4]
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // Transmit ring and serial line
    always @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            sh_q            <= 8'hFF;
            bit_q           <= 3'd0;
            tx_left_q       <= 16'h0000;
            tx_busy_q       <= 1'b0;
            tx_wait_ack_q   <= 1'b0;
            TX_RING_POINTER <= 3'd0;
            TX_DESC_RELEASE <= 1'b0;
            SERIAL_TX_LINE  <= 1'b1;
        end else begin
            TX_DESC_RELEASE <= 1'b0;
            if (!running) begin
                SERIAL_TX_LINE <= 1'b1; // [R14]
                tx_busy_q      <= 1'b0; // [R15]
                tx_wait_ack_q  <= 1'b0;
                bit_q          <= 3'd0;
                sh_q           <= FLAG_OCTET;
            end else begin
                SERIAL_TX_LINE <= sh_q[0]; // [R9]
                bit_q          <= bit_q + 3'd1;
                if (bit_q == 3'd7) begin
                    sh_q <= f_pop ? f_out_data : FLAG_OCTET;
                    if (f_pop) begin
                        tx_left_q <= tx_left_q - 16'h0001;
                    end
                end else begin
                    sh_q <= {1'b1, sh_q[7:1]};
                end
                // Buffer length field is deliberately not read [R1]
                if (!tx_busy_q && !tx_wait_ack_q && tx_own) begin
                    tx_busy_q <= 1'b1; // [R25]
                    tx_left_q <= neg16(TX_DESC_MSG_LEN); // [R2]
                end else if (tx_busy_q && tx_left_q == 16'h0000) begin
                    tx_busy_q     <= 1'b0;
                    tx_wait_ack_q <= 1'b1;
                end else if (tx_wait_ack_q && TX_ACK) begin
                    tx_wait_ack_q   <= 1'b0;
                    TX_DESC_RELEASE <= 1'b1; // [R23]
                    TX_RING_POINTER <= TX_RING_POINTER + 3'd1; // [R6]
                end
            end
        end
    end

    // Receive ring filling
    always @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            rx_cnt_q        <= 16'h0000;
            rx_have_q       <= 1'b0;
            RX_RING_POINTER <= 3'd0;
            RX_DESC_RELEASE <= 1'b0;
            RX_DESC_EOC     <= 1'b0;
            RX_DESC_MSG_LEN <= 16'h0000;
        end else begin
            RX_DESC_RELEASE <= 1'b0;
            if (!running) begin
                rx_cnt_q  <= 16'h0000; // [R15]
                rx_have_q <= 1'b0;
            end else if (rx_own) begin // [R25]
                if (RX_OCTET_VALID) begin
                    rx_cnt_q  <= rx_cnt_q + 16'h0001;
                    rx_have_q <= 1'b1;
                end
                if (RX_FRAME_END && (rx_have_q || RX_OCTET_VALID)) begin
                    RX_DESC_RELEASE <= 1'b1; // [R23]
                    RX_DESC_EOC     <= 1'b1;
                    RX_DESC_MSG_LEN <= neg16(rx_cnt_q +
                        {15'h0000, RX_OCTET_VALID}); // [R2]
                    RX_RING_POINTER <= RX_RING_POINTER + 3'd1; // [R5]
                    rx_cnt_q        <= 16'h0000;
                    rx_have_q       <= 1'b0;
                end
            end
        end
    end
endmodule // drpc_top
`default_nettype wire

// [verif/drpc_chk_sva.sv]
// Concurrent checks on the ports of the ring and primitive control block
`timescale 1ns/1ps
`default_nettype none
`include "drpc_map.vh"
module drpc_chk (
    input wire logic        SYS_CLK,
    input wire logic        NRST,
    input wire logic        PRIM_WR,
    input wire logic [15:0] PRIM_WR_DATA,
    input wire logic [15:0] PRIM_RD_DATA,
    input wire logic [15:0] BUS_CONFIG,
    input wire logic        INIT_FETCH,
    input wire logic        INIT_FETCH_DONE,
    input wire logic        STOP_FLAG,
    input wire logic [7:0]  LOCAL_STATE,
    input wire logic [7:0]  PHASE,
    input wire logic        SERIAL_TX_LINE,
    input wire logic        TX_DESC_RELEASE,
    input wire logic [2:0]  TX_RING_POINTER
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);
    wire stopped = (PHASE == 8'hFF);
    wire wr_stop = PRIM_WR && PRIM_WR_DATA == `DRPC_PRIM_STOP;
    wire wr_test = PRIM_WR && PRIM_WR_DATA == `DRPC_PRIM_SELFTEST;
    property p_line_hi;
        stopped && $past(PHASE) == 8'hFF && $past(PHASE, 2) == 8'hFF
            |-> SERIAL_TX_LINE;
    endproperty
    a_line_hi: assert property (p_line_hi) else $error("line low");
    property p_state;
        (stopped && LOCAL_STATE == 8'h04) ||
            (PHASE == 8'h03 && LOCAL_STATE == 8'h00);
    endproperty
    a_state: assert property (p_state) else $error("bad state");
    property p_start;
        PRIM_WR && PRIM_WR_DATA == 16'h4300 && stopped |=> PHASE == 8'h03;
    endproperty
    a_start: assert property (p_start) else $error("no start");
    property p_init;
        PRIM_WR && PRIM_WR_DATA == 16'h4200 && stopped |=> INIT_FETCH;
    endproperty
    a_init: assert property (p_init) else $error("no fetch");
    property p_init_ack;
        INIT_FETCH_DONE |=> PRIM_RD_DATA == 16'h0242;
    endproperty
    a_init_ack: assert property (p_init_ack) else $error("no confirm");
    property p_clr;
        PRIM_WR && PRIM_WR_DATA == 16'h0040
            |=> PRIM_RD_DATA == ($past(PRIM_RD_DATA) & 16'hFFBF);
    endproperty
    a_clr: assert property (p_clr) else $error("avail not cleared");
    property p_stop;
        wr_stop && PHASE == 8'h03 |=> stopped && STOP_FLAG;
    endproperty
    a_stop: assert property (p_stop) else $error("no stop");
    property p_tx_ptr;
        TX_DESC_RELEASE
            |-> ##2 TX_RING_POINTER == $past(TX_RING_POINTER, 3) + 3'h1;
    endproperty
    a_tx_ptr: assert property (p_tx_ptr) else $error("tx ptr");
    property p_self;
        wr_test && BUS_CONFIG[4] && stopped |-> ##[1:100]
            (PRIM_RD_DATA[6] && PRIM_RD_DATA[4] == (PRIM_RD_DATA[10:8] == 3'h0));
    endproperty
    a_self: assert property (p_self) else $error("test result");
    c_tx: cover property (TX_DESC_RELEASE);
    c_stop: cover property (PHASE == 8'h03 ##1 stopped);
    c_pass: cover property (PRIM_RD_DATA[6] && PRIM_RD_DATA[4]);
endmodule // drpc_chk
bind drpc_top drpc_chk drpc_chk_i (
    .SYS_CLK, .NRST, .PRIM_WR, .PRIM_WR_DATA, .PRIM_RD_DATA, .BUS_CONFIG,
    .INIT_FETCH, .INIT_FETCH_DONE, .STOP_FLAG, .LOCAL_STATE, .PHASE,
    .SERIAL_TX_LINE, .TX_DESC_RELEASE, .TX_RING_POINTER
);
`default_nettype wire

// [verif/drpc_host.sv]
// Host model: descriptor rings in shared memory and init block fetch
`timescale 1ns/1ps
`default_nettype none
module drpc_host #(
    parameter int FETCH_DLY = 5,
    parameter int ACK_DLY   = 200
) (
    input  wire logic        SYS_CLK,
    input  wire logic        NRST,
    input  wire logic        INIT_FETCH,
    output var  logic        INIT_FETCH_DONE,
    input  wire logic [2:0]  TX_RING_POINTER,
    input  wire logic [2:0]  RX_RING_POINTER,
    input  wire logic        TX_DESC_RELEASE,
    input  wire logic        RX_DESC_RELEASE,
    input  wire logic        POST_TX,
    input  wire logic        POST_RX,
    output wire logic [15:0] TX_DESC_FLAGS,
    output wire logic [15:0] RX_DESC_FLAGS,
    output wire logic        TX_ACK
);
    logic [7:0] tx_own_q, rx_own_q;
    logic [2:0] tx_i_q, rx_i_q;
    int         fd_q, ack_q;
    // Single-buffer transmit frames: both chain marks set, bit 11 set; receive flags carry own only
    assign TX_DESC_FLAGS = {tx_own_q[TX_RING_POINTER], 15'h3800};
    assign RX_DESC_FLAGS = {rx_own_q[RX_RING_POINTER], 15'h0000};
    // Slow acknowledge: stalls well past the end of a frame
    assign TX_ACK = tx_own_q[TX_RING_POINTER] && ack_q == ACK_DLY;
    always @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            {tx_own_q, rx_own_q, tx_i_q, rx_i_q} <= 22'h000000;
            fd_q <= 0;
            ack_q <= 0;
            INIT_FETCH_DONE <= 1'b0;
        end else begin
            INIT_FETCH_DONE <= (fd_q == 1);
            fd_q <= INIT_FETCH ? FETCH_DLY : (fd_q > 0 ? fd_q - 1 : 0);
            ack_q <= (TX_ACK || !tx_own_q[TX_RING_POINTER]) ? 0 : ack_q + 1;
            // Only a descriptor the host owns is handed over
            if (POST_TX && !tx_own_q[tx_i_q]) tx_own_q[tx_i_q] <= 1'b1;
            if (POST_RX && !rx_own_q[rx_i_q]) rx_own_q[rx_i_q] <= 1'b1;
            if (TX_DESC_RELEASE) begin
                tx_own_q[tx_i_q] <= 1'b0;
                tx_i_q <= tx_i_q + 3'h1;
            end
            if (RX_DESC_RELEASE) begin
                rx_own_q[rx_i_q] <= 1'b0;
                rx_i_q <= rx_i_q + 3'h1;
            end
        end
    end
endmodule // drpc_host
`default_nettype wire

// [verif/tb_drpc_top.sv]
// Self-checking bench for the ring and primitive control block
`timescale 1ns/1ps
`default_nettype none
`include "drpc_map.vh"
module tb_drpc_top;
    logic        SYS_CLK, NRST, PRIM_WR, STOP_FLAG_CLR, INT_ENABLE_SET;
    logic        TX_DATA_VALID, RX_OCTET_VALID, RX_FRAME_END, post_tx, post_rx;
    logic [15:0] PRIM_WR_DATA, BUS_CONFIG, TX_DESC_MSG_LEN, TX_DESC_BUF_LEN;
    logic [31:0] INIT_POINTER;
    logic [7:0]  TX_DATA, RX_OCTET;
    logic [2:0]  SELF_TEST_RESULT;
    wire         INIT_FETCH, INIT_FETCH_DONE, STOP_FLAG, INT_ENABLE, TX_ACK;
    wire         TX_DESC_RELEASE, TX_DATA_READY, SERIAL_TX_LINE;
    wire         RX_DESC_RELEASE, RX_DESC_EOC;
    wire [15:0]  PRIM_RD_DATA, TX_DESC_FLAGS, RX_DESC_FLAGS, RX_DESC_MSG_LEN;
    wire [31:0]  INIT_FETCH_ADDR;
    wire [7:0]   LOCAL_STATE, PHASE;
    wire [2:0]   RX_RING_POINTER, TX_RING_POINTER;
    int          miscompares = 0, checks_done = 0, cyc = 0, c, n, k;
    logic [15:0] last_q, e, pe, prim_q[$], rx_q[$];
    drpc_top drpc_top_i (
        .SYS_CLK, .NRST, .PRIM_WR_DATA, .PRIM_WR, .PRIM_RD_DATA, .BUS_CONFIG,
        .INIT_POINTER, .INIT_FETCH, .INIT_FETCH_ADDR, .INIT_FETCH_DONE,
        .SELF_TEST_RESULT, .STOP_FLAG, .STOP_FLAG_CLR, .INT_ENABLE,
        .INT_ENABLE_SET, .LOCAL_STATE, .PHASE, .RX_RING_POINTER,
        .TX_RING_POINTER, .TX_DESC_FLAGS, .TX_DESC_MSG_LEN, .TX_DESC_BUF_LEN,
        .TX_DESC_RELEASE, .TX_ACK, .TX_DATA, .TX_DATA_VALID, .TX_DATA_READY,
        .SERIAL_TX_LINE, .RX_DESC_FLAGS, .RX_OCTET_VALID, .RX_OCTET,
        .RX_FRAME_END, .RX_DESC_RELEASE, .RX_DESC_EOC, .RX_DESC_MSG_LEN
    );
    drpc_host #(.FETCH_DLY(5), .ACK_DLY(200)) drpc_host_i (
        .SYS_CLK, .NRST, .INIT_FETCH, .INIT_FETCH_DONE, .TX_RING_POINTER,
        .RX_RING_POINTER, .TX_DESC_RELEASE, .RX_DESC_RELEASE, .POST_TX(post_tx),
        .POST_RX(post_rx), .TX_DESC_FLAGS, .RX_DESC_FLAGS, .TX_ACK
    );
    initial begin
        SYS_CLK = 1'b0;
        forever #12.5 SYS_CLK = ~SYS_CLK;
    end
    task automatic chk(input logic [31:0] got, exp, input string m);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic tick(input int t);
        repeat (t) @(posedge SYS_CLK);
    endtask
    task automatic rst;
        tick(1);
        NRST <= 1'b0;
        tick(3);
        NRST <= 1'b1;
        tick(1);
    endtask
    task automatic prim(input logic [15:0] d);
        PRIM_WR <= 1'b1;
        PRIM_WR_DATA <= d;
        tick(1);
        PRIM_WR <= 1'b0;
        tick(1);
    endtask
    task automatic ones(output int m);
        m = 0;
        repeat (16) begin
            tick(1);
            m += SERIAL_TX_LINE;
        end
    endtask
    always @(posedge SYS_CLK) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            miscompares++;
            $display("[ERR] %0t timeout", $time);
            end_sim();
        end
        if (!NRST) last_q <= 16'h0000;
        else if (PRIM_RD_DATA !== last_q) begin
            last_q <= PRIM_RD_DATA;
            pe = prim_q.size() ? prim_q.pop_front() : last_q;
            chk(PRIM_RD_DATA, pe, "primitive answer");
        end
        if (INIT_FETCH) chk(INIT_FETCH_ADDR, INIT_POINTER, "fetch addr");
        if (RX_DESC_RELEASE)
            chk({RX_DESC_EOC, RX_DESC_MSG_LEN}, {1'b1, rx_q.pop_front()}, "rx");
    end
    initial begin
        {NRST, PRIM_WR, STOP_FLAG_CLR, INT_ENABLE_SET, TX_DATA_VALID} = 5'h00;
        {RX_OCTET_VALID, RX_FRAME_END, post_tx, post_rx} = 4'h0;
        {PRIM_WR_DATA, BUS_CONFIG, TX_DESC_MSG_LEN, TX_DESC_BUF_LEN} = 64'h0;
        {INIT_POINTER, TX_DATA, RX_OCTET, SELF_TEST_RESULT} = 51'h0;
        void'($urandom(32'h4C5B471F));
        rst();
        chk({LOCAL_STATE, PHASE, 10'h000, RX_RING_POINTER, TX_RING_POINTER},
            32'h04FF0000, "reset state");
        INIT_POINTER <= $urandom();
        prim_q.push_back(16'h0242);
        prim(16'h4200);
        while (PRIM_RD_DATA !== 16'h0242) tick(1);
        prim_q.push_back(16'h0202);
        prim(16'h0040);
        prim(16'h4300);
        tick(2);
        chk({LOCAL_STATE, PHASE}, 32'h0003, "run state");
        ones(n);
        chk(n, 12, "idle flags");
        INT_ENABLE_SET <= 1'b1;
        tick(1);
        INT_ENABLE_SET <= 1'b0;
        $display("init and start done");
        TX_DATA_VALID <= 1'b1;
        TX_DATA <= $urandom();
        n = 0;
        do begin
            tick(1);
            n += TX_DATA_READY;
            TX_DATA <= $urandom();
        end while (TX_DATA_READY === 1'b1 && n < 20);
        TX_DATA_VALID <= 1'b0;
        chk(INT_ENABLE, 1, "int enable");
        chk({n[4:0], TX_RING_POINTER}, 32'h80, "fill, own clear");
        TX_DESC_MSG_LEN <= 16'hFFF0;
        TX_DESC_BUF_LEN <= $urandom();
        post_tx <= 1'b1;
        tick(1);
        post_tx <= 1'b0;
        while (TX_DESC_RELEASE !== 1'b1) tick(1);
        tick(3);
        chk({TX_DATA_READY, TX_RING_POINTER}, 32'h9, "tx done");
        $display("transmit done");
        post_rx <= 1'b1;
        tick(1);
        post_rx <= 1'b0;
        k = 1 + $urandom_range(7);
        rx_q.push_back(16'h0000 - k[15:0]);
        repeat (k) begin
            RX_OCTET <= $urandom();
            RX_OCTET_VALID <= 1'b1;
            tick(1);
        end
        RX_OCTET_VALID <= 1'b0;
        RX_FRAME_END <= 1'b1;
        tick(1);
        RX_FRAME_END <= 1'b0;
        while (RX_DESC_RELEASE !== 1'b1) tick(1);
        tick(3);
        chk(RX_RING_POINTER, 1, "rx ptr");
        $display("receive done");
        post_tx <= 1'b1;
        tick(1);
        post_tx <= 1'b0;
        tick(20);
        prim(`DRPC_PRIM_STOP);
        tick(2);
        chk({STOP_FLAG, INT_ENABLE, LOCAL_STATE, PHASE}, 32'h204FF, "stop");
        ones(n);
        chk({n[4:0], TX_RING_POINTER}, {5'd16, 3'h1}, "line high");
        STOP_FLAG_CLR <= 1'b1;
        tick(1);
        STOP_FLAG_CLR <= 1'b0;
        prim(16'h4300);
        tick(2);
        chk({STOP_FLAG, PHASE}, 32'h003, "restart");
        $display("stop and restart done");
        rst();
        prim(`DRPC_PRIM_SELFTEST);
        tick(80);
        chk(PRIM_RD_DATA, 0, "test without enable");
        for (c = 0; c < 8; c++) begin
            BUS_CONFIG <= 16'h0010;
            SELF_TEST_RESULT <= c[2:0];
            rst();
            e = {5'h00, c[2:0], 3'h2, c == 0, 4'h0};
            prim_q.push_back(e);
            prim(`DRPC_PRIM_SELFTEST);
            tick(80);
            chk(PRIM_RD_DATA, e, "self test");
        end
        $display("self test done");
        end_sim();
    end
endmodule // tb_drpc_top
`default_nettype wire
